// file: hw/src_pkg.sv
// Package for the system reset controller: offsets, fields, reset values,
// timing constants and shared types.
// Assumes a 100 MHz pclk and an APB slave with 32-bit data.
package src_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int RELEASE_NS = 100;
  localparam int RELEASE_CYC = (RELEASE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RELEASE_CNT = 4'(RELEASE_CYC);
  localparam int BOOT_NS = 30;
  localparam logic [3:0] BOOT_CNT = 4'((BOOT_NS * CLK_MHZ + 999) / 1000);

  // Register byte offsets
  localparam logic [11:0] OFS_IDENT_A = 12'h000;
  localparam logic [11:0] OFS_IDENT_B = 12'h004;
  localparam logic [11:0] OFS_CAP0 = 12'h008;
  localparam logic [11:0] OFS_SUPPLY_CTL = 12'h030;
  localparam logic [11:0] OFS_CAUSE = 12'h05c;
  localparam logic [11:0] OFS_OSC_CTL = 12'h07c;
  localparam logic [11:0] OFS_PERIPH0 = 12'h040;
  localparam logic [11:0] OFS_PERIPH1 = 12'h044;
  localparam logic [11:0] OFS_PERIPH2 = 12'h048;
  localparam logic [11:0] OFS_CORE_CTL = 12'h0d0;

  // Cause register bit positions
  localparam int CAUSE_EXT = 0;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BOR = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_SW = 4;
  localparam int CAUSE_OSC = 5;
  localparam int CAUSE_W = 6;

  // Control field positions
  localparam int SUPPLY_BOR_EN = 1;
  localparam int OSC_CHECK_EN = 0;
  localparam int CORE_SYSREQ = 2;
  localparam int WDT_RST_EN = 1;

  // Reset values
  localparam logic [31:0] PERIPH_RST_VAL = 32'h0000_0000;
  localparam logic [5:0] CAUSE_RST_VAL = 6'h02;

  // Identification values, arbitrary
  localparam logic [31:0] IDENT_A_VAL = 32'h1234_0001;
  localparam logic [31:0] IDENT_B_VAL = 32'h0000_00a5;
  localparam logic [31:0] CAP0_VAL = 32'h0010_0020;

  // Controller phases, Gray along the usual path
  typedef enum logic [1:0] {
    SRC_HOLD = 2'b00,
    SRC_SYNC = 2'b01,
    SRC_BOOT = 2'b11,
    SRC_RUN = 2'b10
  } src_state_t;

  // Reset requests gathered from the sources
  typedef struct packed {
    logic por;
    logic ext;
    logic bor;
    logic sw;
    logic wdt;
    logic osc;
  } src_req_t;

  // Domain resets, active high
  typedef struct packed {
    logic core;
    logic tap;
    logic tap_pins;
    logic periph;
  } src_dom_t;
endpackage

// file: hw/src_sync.sv
// Reset synchroniser: asserts at once, releases after two pclk edges.
// Assumes a single pclk domain.
`timescale 1ns/1ns
module src_sync (
  // Clock and asynchronous request
  input wire logic pclk,
  input wire logic req_n,
  // Synchronised release
  output logic rst_n
);
  logic stage1;

  // Two flops, reset asynchronously by the request
  always_ff @(posedge pclk or negedge req_n) begin
    if (!req_n) begin
      stage1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      rst_n <= stage1;
    end
  end
endmodule

// file: hw/src_boot.sv
// Boot fetch sequencer: after release, strobes stack pointer, program
// counter and first instruction fetch, then signals execution.
// Assumes the core reacts to one-cycle fetch strobes.
`timescale 1ns/1ns
module src_boot (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  // Fetch strobes
  output logic fetch_sp,
  output logic fetch_pc,
  output logic fetch_insn,
  output logic running
);
  logic [1:0] step;

  // Walks the three fetches in order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step <= 2'h0;
      fetch_sp <= 1'b0;
      fetch_pc <= 1'b0;
      fetch_insn <= 1'b0;
      running <= 1'b0;
    end else begin
      fetch_sp <= 1'b0;
      fetch_pc <= 1'b0;
      fetch_insn <= 1'b0;
      if (!start) begin
        step <= 2'h0;
        running <= 1'b0;
      end else if (!running) begin
        step <= step + 2'h1;
        fetch_sp <= (step == 2'h0);
        fetch_pc <= (step == 2'h1);
        fetch_insn <= (step == 2'h2);
        running <= (step == 2'h3);
      end
    end
  end
endmodule

// file: hw/src_top.sv
// System reset controller: gathers six sources, steers domain resets,
// sequences release and boot fetch, keeps sticky causes, APB registers.
// Assumes sources are synchronous to pclk; presetn is the power-on level.
`timescale 1ns/1ns
module src_top (
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources
  input wire logic ext_rst_n,
  input wire logic brownout_low,
  input wire logic wdt_second_timeout,
  input wire logic osc_fail_detect,
  // Domain resets, active low
  output logic core_rst_n,
  output logic tap_rst_n,
  output logic tap_pins_rst_n,
  output logic [95:0] periph_rst_n,
  // Brown-out interrupt request
  output logic brownout_irq,
  // Oscillator check enable to detector
  output logic osc_check_enable,
  // Boot fetch strobes
  output logic fetch_sp,
  output logic fetch_pc,
  output logic fetch_insn,
  output logic core_running
);
  src_pkg::src_req_t req;
  src_pkg::src_state_t state;
  src_pkg::src_state_t next_state;
  logic [31:0] supply_reset_control_reg;
  logic [31:0] main_osc_control_reg;
  logic [31:0] core_int_reset_control;
  logic [31:0] peripheral_reset_regs [3];
  logic [src_pkg::CAUSE_W-1:0] reset_cause_reg;
  logic system_reset_request;
  logic any_req;
  logic sys_rst_n;
  logic [3:0] cnt;
  logic in_reset;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [31:0] rd_val;

  // Word match helper used by read and write decode
  function automatic logic at(input logic [11:0] a, input logic [11:0] o);
    at = (a[11:2] == o[11:2]);
  endfunction

  // Cause bits raised by live requests; power-on is set by presetn alone
  function automatic logic [src_pkg::CAUSE_W-1:0] set_mask(
    input src_pkg::src_req_t r);
    set_mask = '0;
    set_mask[src_pkg::CAUSE_EXT] = r.ext;
    set_mask[src_pkg::CAUSE_BOR] = r.bor;
    set_mask[src_pkg::CAUSE_WDT] = r.wdt;
    set_mask[src_pkg::CAUSE_SW] = r.sw;
    set_mask[src_pkg::CAUSE_OSC] = r.osc;
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign system_reset_request = core_int_reset_control[src_pkg::CORE_SYSREQ];

  // Gather the six sources
  always_comb begin
    req.por = !presetn; // power-on is the presetn level itself
    req.ext = !ext_rst_n;
    req.bor = brownout_low &&
      supply_reset_control_reg[src_pkg::SUPPLY_BOR_EN];
    req.sw = system_reset_request;
    req.wdt = wdt_second_timeout;
    req.osc = osc_fail_detect &&
      main_osc_control_reg[src_pkg::OSC_CHECK_EN];
  end

  assign any_req = |req;
  assign brownout_irq = brownout_low &&
    !supply_reset_control_reg[src_pkg::SUPPLY_BOR_EN];
  assign osc_check_enable = main_osc_control_reg[src_pkg::OSC_CHECK_EN];

  // Combined request with synchronised release
  src_sync u_sync (
    .pclk(pclk),
    .req_n(presetn && !any_req),
    .rst_n(sys_rst_n)
  );

  // Release sequencer
  always_comb begin
    next_state = state;
    case (state)
      src_pkg::SRC_HOLD: begin
        if (sys_rst_n) begin
          next_state = src_pkg::SRC_SYNC;
        end
      end
      src_pkg::SRC_SYNC: begin
        if (cnt == src_pkg::RELEASE_CNT) begin
          next_state = src_pkg::SRC_BOOT;
        end
      end
      src_pkg::SRC_BOOT: begin
        if (core_running) begin
          next_state = src_pkg::SRC_RUN;
        end
      end
      src_pkg::SRC_RUN: begin
        next_state = src_pkg::SRC_RUN;
      end
      default: begin
        next_state = src_pkg::SRC_HOLD;
      end
    endcase
    if (!sys_rst_n) begin
      next_state = src_pkg::SRC_HOLD;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= src_pkg::SRC_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Release delay counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
    end else if (state == src_pkg::SRC_SYNC) begin
      cnt <= cnt + 4'h1;
    end else begin
      cnt <= 4'h0;
    end
  end

  assign in_reset = (state == src_pkg::SRC_HOLD) ||
    (state == src_pkg::SRC_SYNC);

  // Domain resets: core from every system source, test port from power-on only, test pins from power-on and the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rst_n <= 1'b0;
      tap_rst_n <= 1'b0;
      tap_pins_rst_n <= 1'b0;
    end else begin
      core_rst_n <= !in_reset;
      tap_rst_n <= 1'b1;
      tap_pins_rst_n <= ext_rst_n;
    end
  end

  // Peripheral resets: system reset or the unit's own bit, all domains
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_rst_n <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        periph_rst_n[i*32 +: 32] <=
          ~(peripheral_reset_regs[i] | {32{in_reset}});
      end
    end
  end

  // Boot fetch after release
  src_boot u_boot (
    .pclk(pclk),
    .presetn(presetn),
    .start(state == src_pkg::SRC_BOOT || state == src_pkg::SRC_RUN),
    .fetch_sp(fetch_sp),
    .fetch_pc(fetch_pc),
    .fetch_insn(fetch_insn),
    .running(core_running)
  );

  // Sticky cause bits; set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_cause_reg <= src_pkg::CAUSE_RST_VAL;
    end else begin
      if (wr_en && at(paddr, src_pkg::OFS_CAUSE)) begin
        reset_cause_reg <= pwdata[src_pkg::CAUSE_W-1:0] |
          set_mask(req);
      end else begin
        reset_cause_reg <= reset_cause_reg |
          set_mask(req);
      end
    end
  end

  // Control registers; cleared by power-on only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_reset_control_reg <= 32'h0000_0000;
      main_osc_control_reg <= 32'h0000_0000;
    end else if (wr_en) begin
      if (at(paddr, src_pkg::OFS_SUPPLY_CTL)) begin
        supply_reset_control_reg <= {30'h0, pwdata[1], 1'b0};
      end
      if (at(paddr, src_pkg::OFS_OSC_CTL)) begin
        main_osc_control_reg <= {31'h0, pwdata[0]};
      end
    end
  end

  // System request bit self-clears once reset has taken hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_int_reset_control <= 32'h0000_0000;
    end else if (wr_en && at(paddr, src_pkg::OFS_CORE_CTL)) begin
      core_int_reset_control <= {29'h0, pwdata[2], 2'h0};
    end else if (!sys_rst_n) begin
      core_int_reset_control <= 32'h0000_0000;
    end
  end

  // Peripheral reset registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        peripheral_reset_regs[i] <= src_pkg::PERIPH_RST_VAL;
      end
    end else if (wr_en) begin
      if (at(paddr, src_pkg::OFS_PERIPH0)) begin
        peripheral_reset_regs[0] <= pwdata;
      end
      if (at(paddr, src_pkg::OFS_PERIPH1)) begin
        peripheral_reset_regs[1] <= pwdata;
      end
      if (at(paddr, src_pkg::OFS_PERIPH2)) begin
        peripheral_reset_regs[2] <= pwdata;
      end
    end
  end

  // Read mux
  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (at(paddr, src_pkg::OFS_IDENT_A)) begin
      rd_val = src_pkg::IDENT_A_VAL;
    end else if (at(paddr, src_pkg::OFS_IDENT_B)) begin
      rd_val = src_pkg::IDENT_B_VAL;
    end else if (at(paddr, src_pkg::OFS_CAP0)) begin
      rd_val = src_pkg::CAP0_VAL;
    end else if (at(paddr, src_pkg::OFS_SUPPLY_CTL)) begin
      rd_val = supply_reset_control_reg;
    end else if (at(paddr, src_pkg::OFS_CAUSE)) begin
      rd_val = {26'h0, reset_cause_reg};
    end else if (at(paddr, src_pkg::OFS_OSC_CTL)) begin
      rd_val = main_osc_control_reg;
    end else if (at(paddr, src_pkg::OFS_PERIPH0)) begin
      rd_val = peripheral_reset_regs[0];
    end else if (at(paddr, src_pkg::OFS_PERIPH1)) begin
      rd_val = peripheral_reset_regs[1];
    end else if (at(paddr, src_pkg::OFS_PERIPH2)) begin
      rd_val = peripheral_reset_regs[2];
    end else if (at(paddr, src_pkg::OFS_CORE_CTL)) begin
      rd_val = core_int_reset_control;
    end else begin
      hit = 1'b0;
    end
  end

  // Read data captured in setup, error flagged for unmapped words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rd_en ? rd_val : 32'h0000_0000;
      pslverr <= !hit;
    end
  end

  // Checks
  bor_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    brownout_low && !supply_reset_control_reg[src_pkg::SUPPLY_BOR_EN]
    |-> brownout_irq && !req.bor)
    else $error("brown-out reset without enable");
  bor_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.bor |-> ##2 !core_rst_n)
    else $error("brown-out did not hold core");
  cause_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.wdt |=> reset_cause_reg[src_pkg::CAUSE_WDT])
    else $error("watchdog cause not set");
  ext_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.ext |=> reset_cause_reg[src_pkg::CAUSE_EXT])
    else $error("pin cause not set");
  cause_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    reset_cause_reg[src_pkg::CAUSE_POR] &&
    !(wr_en && at(paddr, src_pkg::OFS_CAUSE))
    |=> reset_cause_reg[src_pkg::CAUSE_POR])
    else $error("cause bit lost");
  tap_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> tap_rst_n)
    else $error("test port reset by non power-on source");
  sys_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    req.sw |-> ##[1:3] !core_rst_n)
    else $error("system request did not reset core");
  periph_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    peripheral_reset_regs[0] != 32'h0000_0000
    |=> (periph_rst_n[31:0] & $past(peripheral_reset_regs[0])) ==
      32'h0000_0000)
    else $error("peripheral bit did not reset unit");
  boot_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_sp |=> fetch_pc ##1 fetch_insn)
    else $error("boot fetch out of order");
  release_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(core_rst_n) |-> $past(state, 2) == src_pkg::SRC_SYNC)
    else $error("core released without sync phase");
endmodule

// file: tb/src_far_model.sv
// Far-side model: reset pin, supply monitor, watchdog and oscillator
// detector feeding the reset controller.
// Assumes bench requests change just after a rising pclk edge.
`timescale 1ns/1ns
module src_far_model #(
  parameter int MIN_PULSE = 4
) (
  // Clock
  input wire logic pclk,
  // Requests from the bench
  input wire logic pin_req,
  input wire logic supply_req,
  input wire logic wdt_req,
  input wire logic osc_req,
  // Levels toward the controller
  output logic ext_rst_n = 1'b1,
  output logic brownout_low = 1'b0,
  output logic wdt_second_timeout = 1'b0,
  output logic osc_fail_detect = 1'b0
);
  int hold_cnt = 0;

  // Pin is held low at least the minimum pulse width, then released
  always @(posedge pclk) begin
    if (pin_req) begin
      ext_rst_n <= 1'b0;
      hold_cnt <= MIN_PULSE - 1;
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end else begin
      ext_rst_n <= 1'b1;
    end
  end

  // Supply, watchdog and oscillator levels follow their requests
  always @(posedge pclk) begin
    brownout_low <= supply_req;
    wdt_second_timeout <= wdt_req;
    osc_fail_detect <= osc_req;
  end
endmodule

// file: tb/system_reset_control_tb_top.sv
// Self-checking bench for the system reset controller.
// Assumes zero-wait APB and the far-side model driving the sources.
`timescale 1ns/1ns
module system_reset_control_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic ext_rst_n, brownout_low, wdt_second_timeout, osc_fail_detect;
  logic core_rst_n, tap_rst_n, tap_pins_rst_n;
  logic [95:0] periph_rst_n;
  logic brownout_irq, osc_check_enable;
  logic fetch_sp, fetch_pc, fetch_insn, core_running;
  logic pin_req = 1'b0;
  logic supply_req = 1'b0;
  logic wdt_req = 1'b0;
  logic osc_req = 1'b0;
  int miscompares = 0;
  int total_checks = 0;

  // 100 MHz clock
  always #5 pclk = ~pclk;

  src_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_rst_n(ext_rst_n), .brownout_low(brownout_low),
    .wdt_second_timeout(wdt_second_timeout),
    .osc_fail_detect(osc_fail_detect), .core_rst_n(core_rst_n),
    .tap_rst_n(tap_rst_n), .tap_pins_rst_n(tap_pins_rst_n),
    .periph_rst_n(periph_rst_n), .brownout_irq(brownout_irq),
    .osc_check_enable(osc_check_enable), .fetch_sp(fetch_sp),
    .fetch_pc(fetch_pc), .fetch_insn(fetch_insn),
    .core_running(core_running));

  src_far_model far (.pclk(pclk), .pin_req(pin_req),
    .supply_req(supply_req), .wdt_req(wdt_req), .osc_req(osc_req),
    .ext_rst_n(ext_rst_n), .brownout_low(brownout_low),
    .wdt_second_timeout(wdt_second_timeout),
    .osc_fail_detect(osc_fail_detect));

  // Compare and count
  task automatic chk(input logic [95:0] seen, exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("unexpected at %0t: no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for release, then the three fetch strobes and run
  task automatic wait_boot();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (fetch_sp !== 1'b1 && n < 300);
    chk({fetch_sp, core_rst_n}, 2'b11, "no stack fetch");
    @(posedge pclk);
    #1;
    chk({fetch_sp, fetch_pc, fetch_insn}, 3'b010, "pc fetch");
    @(posedge pclk);
    #1;
    chk({fetch_pc, fetch_insn}, 2'b01, "insn fetch");
    @(posedge pclk);
    #1;
    chk(core_running, 1'b1, "not running");
  endtask

  task automatic cause_is(input logic [31:0] exp);
    apb(1'b1 ^ 1'b1, src_pkg::OFS_CAUSE, 32'h0);
    chk(rd, exp, "cause value");
  endtask

  // Hold watchdog or oscillator request four cycles
  task automatic pulse_src(input logic [1:0] k);
    @(posedge pclk);
    wdt_req <= k[0];
    osc_req <= k[1];
    repeat (4) @(posedge pclk);
    wdt_req <= 1'b0;
    osc_req <= 1'b0;
    #1;
  endtask

  task automatic t_regs();
    cause_is(32'h2);
    apb(1'b1, src_pkg::OFS_IDENT_A, 32'h0);
    apb(1'b0, src_pkg::OFS_IDENT_A, 32'h0);
    chk(rd, src_pkg::IDENT_A_VAL, "ident");
    apb(1'b0, 12'h100, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
    $display("test regs done");
  endtask

  task automatic t_pin();
    @(posedge pclk);
    pin_req <= 1'b1;
    @(posedge pclk);
    pin_req <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk({core_rst_n, tap_rst_n, tap_pins_rst_n}, 3'b010, "pin");
    chk(periph_rst_n, 96'h0, "pin periph");
    wait_boot();
    cause_is(32'h3);
    $display("test pin done");
  endtask

  task automatic t_bor();
    @(posedge pclk);
    supply_req <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    chk({brownout_irq, core_rst_n}, 2'b11, "bor disabled");
    supply_req <= 1'b0;
    apb(1'b1, src_pkg::OFS_SUPPLY_CTL, 32'h2);
    supply_req <= 1'b1;
    repeat (30) @(posedge pclk);
    #1;
    chk({brownout_irq, core_rst_n, tap_rst_n}, 3'b001, "bor");
    supply_req <= 1'b0;
    wait_boot();
    cause_is(32'h7);
    $display("test bor done");
  endtask

  task automatic t_periph();
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, src_pkg::OFS_PERIPH0 + 12'(4 * r), 32'h80 << r);
      @(posedge pclk);
      #1;
      chk(periph_rst_n, ~(96'h80 << (33 * r)), "periph");
      chk(core_rst_n, 1'b1, "core hit");
      apb(1'b1, src_pkg::OFS_PERIPH0 + 12'(4 * r), 32'h0);
      @(posedge pclk);
      #1;
      chk(periph_rst_n, ~96'h0, "periph release");
    end
    $display("test periph done");
  endtask

  task automatic t_sys();
    apb(1'b1, src_pkg::OFS_CORE_CTL, 32'h4);
    repeat (4) @(posedge pclk);
    #1;
    chk({core_rst_n, tap_rst_n}, 2'b01, "sys request");
    wait_boot();
    cause_is(32'h17);
    pulse_src(2'b01);
    chk(core_rst_n, 1'b0, "watchdog");
    wait_boot();
    cause_is(32'h1f);
    pulse_src(2'b10);
    chk(core_rst_n, 1'b1, "osc unarmed");
    apb(1'b1, src_pkg::OFS_OSC_CTL, 32'h1);
    @(posedge pclk);
    #1;
    chk(osc_check_enable, 1'b1, "osc armed");
    pulse_src(2'b10);
    chk(core_rst_n, 1'b0, "osc fail");
    wait_boot();
    cause_is(32'h3f);
    $display("test sys done");
  endtask

  task automatic t_por();
    apb(1'b1, src_pkg::OFS_CAUSE, 32'h0);
    cause_is(32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    #1;
    chk({core_rst_n, tap_rst_n, fetch_sp}, 3'b000, "por");
    chk(periph_rst_n, 96'h0, "por periph");
    @(posedge pclk);
    presetn <= 1'b1;
    wait_boot();
    cause_is(32'h2);
    $display("test por done");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_boot();
    t_regs();
    t_pin();
    t_bor();
    t_periph();
    t_sys();
    t_por();
    test_done();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
endmodule
